/* lsc_pkg.sv */
// Package of constants and carrier types for the checked dual local store.
`default_nettype none
package lsc_pkg;
  localparam int LSC_DEPTH    = 64;         // Words per stack
  localparam int LSC_AW       = 6;          // Word address width
  localparam logic [5:0] LSC_ADDR_LO = 6'h00; // Lowest decoded word
  localparam logic [5:0] LSC_ADDR_HI = 6'h3f; // Highest decoded word
  localparam int LSC_DW       = 32;         // Four bytes per word
  // Bit positions, numbered 0 = most significant in each 8-bit register
  localparam int LSC_SEL_WORD = 7 - 5;      // byte_select_reg bit 5
  localparam int LSC_SEL_HALF = 7 - 6;      // byte_select_reg bit 6
  localparam int LSC_SEL_BYTE = 7 - 7;      // byte_select_reg bit 7
  localparam int LSC_MCK_CMP  = 7 - 1;      // machine_check_reg_one bit 1
  localparam int LSC_MCK_FTC  = 7 - 2;      // machine_check_reg_one bit 2
  localparam int LSC_DG_BLK   = 7 - 4;      // diag_control_zero bit 4
  localparam int LSC_DG_XY    = 7 - 5;      // diag_control_zero bit 5
  localparam int LSC_RT_X     = 31 - 5;     // retry_hold_assembler byte 0 bit 5
  localparam int LSC_RT_Y     = 31 - 6;     // retry_hold_assembler byte 0 bit 6
  localparam int LSC_RT_WR    = 7 - 6;      // retry_hold_assembler byte 3 bit 6
  localparam logic [7:0]  LSC_MCK_RST  = 8'h00;
  localparam logic [31:0] LSC_WORD_RST = 32'h0000_0000;
  localparam logic [5:0]  LSC_ADDR_RST = 6'h00;

  // How a source address is formed
  typedef enum logic [2:0] {
    LSA_DIRECT, LSA_GPR_HI, LSA_GPR_LO, LSA_FPR, LSA_MASK
  } lsc_amode_e;

  // Output assembler selection
  typedef enum logic [1:0] {
    ASM_WORD, ASM_HALF, ASM_PAIR, ASM_BYTE
  } lsc_asm_e;

  // Per-source addressing request
  typedef struct packed {
    logic       rd;     // Read this stack
    lsc_amode_e mode;   // Address formation
    logic [5:0] field;  // Control-word address bits
  } lsc_src_s;

  // Local-store part of a control word
  typedef struct packed {
    lsc_src_s src_a;    // Source for stack_one
    lsc_src_s src_b;    // Source for stack_two
    logic     dest_en;  // Word destined to local store
    logic     dest_b;   // Destination taken from B buffer
    logic     from_sto; // Data from storage-word read
    lsc_asm_e asm_mode; // Assembler selection
    logic     prot;     // Storage-protect key into byte 3
  } lsc_cw_s;

  // Forced address bits from channel and console
  typedef struct packed {
    logic       chan_en;
    logic [5:0] chan_addr;
    logic       cons_en;
    logic [5:0] cons_addr;
  } lsc_force_s;
endpackage
`default_nettype wire

/* lsc_store.sv */
// Duplicated 64-word local store with assembler, deferred write and checks.
`default_nettype none
// How it works
// RQ1 - Two stacks of 64 four-byte words
// RQ2 - Word addresses 00 through 3F decoded
// RQ3 - Each destined word written into both stacks; stack_one is not written while blk_one is high
// RQ4 - Both stacks read per cycle, separate addresses
// RQ5 - Destined data written and checked next cycle
// RQ6 - Every write followed by read-back of location
// RQ7 - Write source mismatch sets check bit 2
// RQ8 - Stack read-back mismatch sets check bit 1
// RQ9 - Source addresses captured into destination buffers
// RQ10 - Previous destination address drives write decode
// RQ11 - Selected buffer loads the destination latch
// RQ12 - Source equal previous destination uses sum hold
// RQ13 - Bypass decided separately for each byte
// RQ14 - Assembler feeds input bus and local store
// RQ15 - Select bit 5 picks even/odd word
// RQ16 - Select bit 6 picks even/odd halfword
// RQ17 - Select bit 7 picks even/odd bytes
// RQ18 - Select bits 6,7 route one byte
// RQ19 - Diagnostic forces extra X line
// RQ20 - Diagnostic forces extra Y line
// RQ21 - Register number from either pointer nibble
// RQ22 - Addresses formed from many control sources
// RQ23 - X/Y check unless exactly one line each
// RQ24 - Diagnostic blocks stack_one writes
// RQ25 - Check bits stay until cleared
module lsc_store
  import lsc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Control word and address sources
  input  wire lsc_cw_s     cw_i,
  input  wire lsc_force_s  force_i,
  input  wire logic [7:0]  base_index_reg_i,
  input  wire logic [7:0]  gpr_pointer_reg_i,
  input  wire logic [7:0]  mask_aux_reg_i,
  // Data sources
  input  wire logic [63:0] pre_asm_dw_i,
  input  wire logic [7:0]  prot_key_i,
  input  wire logic [31:0] write_source_reg_i,
  input  wire logic [31:0] sum_hold_reg_i,
  input  wire logic [7:0]  byte_select_reg_i,
  // Diagnostic and check control
  input  wire logic [7:0]  diag_control_zero_i,
  input  wire logic [31:0] retry_hold_assembler_i,
  input  wire logic        mck_clear_i,
  // Results
  output logic [31:0]      first_input_reg_o,
  output logic [31:0]      second_input_reg_o,
  output logic [31:0]      external_input_bus_o,
  output logic [7:0]       machine_check_reg_one_o,
  output logic             x_check_o,
  output logic             y_check_o
);

  logic [31:0] stack_one [LSC_DEPTH];   // [RQ1]
  logic [31:0] stack_two [LSC_DEPTH];   // Duplicate copy
  logic [5:0]  addr_a;                  // Source address for stack_one
  logic [5:0]  addr_b;                  // Source address for stack_two
  logic [5:0]  buf_a;                   // Destination buffer A
  logic [5:0]  buf_b;                   // Destination buffer B
  logic [5:0]  dest_latch;              // Last written address
  logic [5:0]  wr_addr;                 // Address written this cycle
  logic        pend_en;                 // A write is pending
  logic        pend_b;                  // Pending buffer choice
  logic        pend_ftc;                // Pending write is checked by WRITE_ECHO_CHECK
  logic [31:0] pend_data;               // Pending write data, assembler or write source
  logic [3:0]  pend_mask;               // Pending byte lanes
  logic        rb_en;                   // Read-back due this cycle
  logic        rb_ftc;                  // Read-back needs WRITE_ECHO_CHECK
  logic [31:0] rb_data;                 // Data that was written
  logic [3:0]  rb_mask;                 // Lanes that were written
  logic        blk_one;                 // stack_one writes blocked
  logic [31:0] asm_word;                // Assembler output
  logic [3:0]  asm_mask;                // Assembler lanes
  logic [31:0] wr_data;                 // Data for the stacks
  logic [7:0]  x_lines;                 // X decode with forcing
  logic [7:0]  y_lines;                 // Y decode with forcing

  // Address formation from control word, pointers and forced bits
  function automatic logic [5:0] form_addr(input lsc_src_s s);
    logic [5:0] a;
    a = s.field;
    case (s.mode)
      LSA_DIRECT: a = s.field;
      LSA_GPR_HI: a = {base_index_reg_i[1:0], gpr_pointer_reg_i[7:4]};  // [RQ21]
      LSA_GPR_LO: a = {base_index_reg_i[1:0], gpr_pointer_reg_i[3:0]};  // [RQ21]
      LSA_FPR:    a = {base_index_reg_i[1:0], gpr_pointer_reg_i[7:4]};  // [RQ21]
      LSA_MASK:   a = {s.field[5:4], mask_aux_reg_i[3:0]};
      default:    a = s.field;
    endcase
    if (force_i.chan_en) begin
      a = force_i.chan_addr;              // [RQ22]
    end
    if (force_i.cons_en) begin
      a = force_i.cons_addr;              // [RQ22]
    end
    return a;
  endfunction

  // Source addresses
  always_comb begin
    addr_a = form_addr(cw_i.src_a);       // [RQ22]
    addr_b = form_addr(cw_i.src_b);
  end

  // Output assembler: word, halfword, byte pair or single byte
  always_comb begin
    logic [31:0] w;
    logic [15:0] h;
    logic [15:0] p;
    logic [7:0]  b;
    b = 8'h00;                            // Single-byte lane, set by the decode below
    w = byte_select_reg_i[LSC_SEL_WORD] ? pre_asm_dw_i[31:0] : pre_asm_dw_i[63:32];   // [RQ15]
    h = byte_select_reg_i[LSC_SEL_HALF] ? w[15:0] : w[31:16];                          // [RQ16]
    p = byte_select_reg_i[LSC_SEL_BYTE] ? {w[23:16], w[7:0]} : {w[31:24], w[15:8]};    // [RQ17]
    case ({byte_select_reg_i[LSC_SEL_HALF], byte_select_reg_i[LSC_SEL_BYTE]})         // [RQ18]
      2'b00:   b = w[31:24];
      2'b01:   b = w[23:16];
      2'b10:   b = w[15:8];
      default: b = w[7:0];
    endcase
    case (cw_i.asm_mode)
      ASM_WORD: begin
        asm_word = w;
        asm_mask = 4'hf;
      end
      ASM_HALF: begin
        asm_word = {16'h0000, h};
        asm_mask = 4'h3;
      end
      ASM_PAIR: begin
        asm_word = {8'h00, p[15:8], 8'h00, p[7:0]};
        asm_mask = 4'h5;
      end
      default: begin
        asm_word = {24'h000000, b};
        asm_mask = 4'h1;
      end
    endcase
    if (cw_i.prot) begin
      asm_word[7:0] = prot_key_i;         // Storage-protect key in byte 3
    end
  end

  // Input bus from the assembler
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      external_input_bus_o <= LSC_WORD_RST;
    end else begin
      external_input_bus_o <= asm_word;   // [RQ14]
    end
  end

  // Fast gate: capture source addresses as destination buffers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      buf_a <= LSC_ADDR_RST;
      buf_b <= LSC_ADDR_RST;
    end else begin
      buf_a <= addr_a;                    // [RQ9]
      buf_b <= addr_b;                    // [RQ9]
    end
  end

  // Deferred write: hold destined data one cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pend_en   <= 1'b0;
      pend_b    <= 1'b0;
      pend_ftc  <= 1'b0;
      pend_data <= LSC_WORD_RST;
      pend_mask <= 4'h0;
    end else begin
      pend_en   <= cw_i.dest_en;          // [RQ5]
      pend_b    <= cw_i.dest_b;
      pend_ftc  <= !cw_i.from_sto;
      // Storage-word reads take assembler data, others the write source
      pend_data <= cw_i.from_sto ? asm_word : write_source_reg_i;   // [RQ7] [RQ14]
      pend_mask <= cw_i.from_sto ? asm_mask : 4'hf;
    end
  end

  // Write address is the buffer chosen by the previous control word
  always_comb begin
    wr_addr = pend_b ? buf_b : buf_a;     // [RQ10]
    blk_one = (diag_control_zero_i[LSC_DG_BLK] || diag_control_zero_i[LSC_DG_XY]) &&
              !retry_hold_assembler_i[LSC_RT_WR];                   // [RQ24]
  end

  // Lane merge of pending data over the stored word
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_data[i*8 +: 8] = pend_mask[i] ? pend_data[i*8 +: 8] : stack_two[wr_addr][i*8 +: 8];
    end
  end

  // Both stacks written at the same address, stack_one only while blk_one is low; full 00-3F range decoded
  generate
    for (genvar g = 0; g < LSC_DEPTH; g++) begin : g_word
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          stack_one[g] <= LSC_WORD_RST;
          stack_two[g] <= LSC_WORD_RST;
        end else if (pend_en && wr_addr == 6'(g)) begin   // [RQ2] [RQ3]
          if (!blk_one) begin
            stack_one[g] <= wr_data;      // [RQ3]
          end
          stack_two[g] <= wr_data;        // [RQ3]
        end
      end
    end
  endgenerate

  // Destination latch and read-back bookkeeping
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dest_latch <= LSC_ADDR_RST;
      rb_en      <= 1'b0;
      rb_ftc     <= 1'b0;
      rb_data    <= LSC_WORD_RST;
      rb_mask    <= 4'h0;
    end else begin
      if (pend_en) begin
        dest_latch <= wr_addr;            // [RQ11]
      end
      rb_en   <= pend_en;                 // [RQ6]
      rb_ftc  <= pend_en && pend_ftc;
      rb_data <= wr_data;
      rb_mask <= pend_mask;
    end
  end

  // X/Y line decode with diagnostic forcing on the write access
  always_comb begin
    x_lines = 8'h01 << wr_addr[5:3];
    y_lines = 8'h01 << wr_addr[2:0];
    if (diag_control_zero_i[LSC_DG_XY] && !retry_hold_assembler_i[LSC_RT_X]) begin
      x_lines = x_lines | {x_lines[6:0], x_lines[7]};   // [RQ19]
    end
    if (diag_control_zero_i[LSC_DG_XY] && !retry_hold_assembler_i[LSC_RT_Y]) begin
      y_lines = y_lines | {y_lines[6:0], y_lines[7]};   // [RQ20]
    end
  end

  // X/Y checks flag anything but exactly one line
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      x_check_o <= 1'b0;
      y_check_o <= 1'b0;
    end else begin
      x_check_o <= pend_en && !$onehot(x_lines);   // [RQ23]
      y_check_o <= pend_en && !$onehot(y_lines);   // [RQ23]
    end
  end

  // Read-back checks; set wins over clear, bits stay until cleared
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      machine_check_reg_one_o <= LSC_MCK_RST;
    end else begin
      for (int i = 0; i < 8; i++) begin
        logic set;
        set = 1'b0;
        if (i == LSC_MCK_FTC) begin
          set = rb_ftc && (rb_data != stack_one[dest_latch]);                 // [RQ7]
        end
        if (i == LSC_MCK_CMP) begin
          set = rb_en && (stack_one[dest_latch] != stack_two[dest_latch]);    // [RQ8]
        end
        if (set) begin
          machine_check_reg_one_o[i] <= 1'b1;
        end else if (mck_clear_i) begin
          machine_check_reg_one_o[i] <= 1'b0;                                  // [RQ25]
        end
      end
    end
  end

  // Source reads with per-byte look-ahead bypass from sum hold
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      first_input_reg_o  <= LSC_WORD_RST;
      second_input_reg_o <= LSC_WORD_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cw_i.src_a.rd) begin          // [RQ4]
          first_input_reg_o[i*8 +: 8] <= (pend_en && pend_mask[i] && addr_a == wr_addr) ?
            sum_hold_reg_i[i*8 +: 8] : stack_one[addr_a][i*8 +: 8];          // [RQ12] [RQ13]
        end
        if (cw_i.src_b.rd) begin          // [RQ4]
          second_input_reg_o[i*8 +: 8] <= (pend_en && pend_mask[i] && addr_b == wr_addr) ?
            sum_hold_reg_i[i*8 +: 8] : stack_two[addr_b][i*8 +: 8];          // [RQ12] [RQ13]
        end
      end
    end
  end

endmodule
`default_nettype wire

/* lsc_store_chk.sv */
// Port checker for the checked dual local store.
`default_nettype none
module lsc_store_chk
  import lsc_pkg::*;
(
  // Clock, reset and controls
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire lsc_cw_s     cw_i,
  input  wire logic [7:0]  diag_control_zero_i,
  input  wire logic [31:0] retry_hold_assembler_i,
  input  wire logic        mck_clear_i,
  // Results
  input  wire logic [31:0] first_input_reg_o,
  input  wire logic [31:0] second_input_reg_o,
  input  wire logic [7:0]  machine_check_reg_one_o,
  input  wire logic        x_check_o,
  input  wire logic        y_check_o
);
  // Diagnostic forcing and write blocking conditions
  logic fx, fy, blk, dx;
  assign dx  = diag_control_zero_i[LSC_DG_XY];
  assign fx  = dx && !retry_hold_assembler_i[LSC_RT_X];
  assign fy  = dx && !retry_hold_assembler_i[LSC_RT_Y];
  assign blk = (diag_control_zero_i[LSC_DG_BLK] || dx) && !retry_hold_assembler_i[LSC_RT_WR];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_xline; cw_i.dest_en && fx ##1 fx |=> x_check_o; endproperty
  a_xline: assert property (p_xline) else $error("forced X line not flagged");
  property p_yline; cw_i.dest_en && fy ##1 fy |=> y_check_o; endproperty
  a_yline: assert property (p_yline) else $error("forced Y line not flagged");
  property p_clean; cw_i.dest_en && !dx ##1 !dx |=> !x_check_o && !y_check_o; endproperty
  a_clean: assert property (p_clean) else $error("line check without forcing");
  property p_block; cw_i.dest_en && !cw_i.from_sto && blk ##1 blk |=> ##1
    machine_check_reg_one_o[LSC_MCK_CMP] && machine_check_reg_one_o[LSC_MCK_FTC]; endproperty
  a_block: assert property (p_block) else $error("blocked write not flagged");
  property p_keep; !mck_clear_i |=> (machine_check_reg_one_o[6:5] & $past(machine_check_reg_one_o[6:5]))
    == $past(machine_check_reg_one_o[6:5]); endproperty
  a_keep: assert property (p_keep) else $error("check bit dropped");
  property p_clear; !cw_i.dest_en [*2] ##1 mck_clear_i |=> machine_check_reg_one_o[6:5] == 2'b00; endproperty
  a_clear: assert property (p_clear) else $error("check bits not cleared");
  property p_ftc; $rose(machine_check_reg_one_o[LSC_MCK_FTC]) |-> $past(cw_i.dest_en, 3); endproperty
  a_ftc: assert property (p_ftc) else $error("echo check without write");
  property p_cmp; $rose(machine_check_reg_one_o[LSC_MCK_CMP]) |-> $past(cw_i.dest_en, 3); endproperty
  a_cmp: assert property (p_cmp) else $error("compare check without write");
  property p_hold_a; !cw_i.src_a.rd |=> $stable(first_input_reg_o); endproperty
  a_hold_a: assert property (p_hold_a) else $error("first input changed unread");
  property p_hold_b; !cw_i.src_b.rd |=> $stable(second_input_reg_o); endproperty
  a_hold_b: assert property (p_hold_b) else $error("second input changed unread");
endmodule
bind lsc_store lsc_store_chk i_lsc_store_chk (.mclk_i, .reset_i, .cw_i, .diag_control_zero_i,
  .retry_hold_assembler_i, .mck_clear_i, .first_input_reg_o, .second_input_reg_o,
  .machine_check_reg_one_o, .x_check_o, .y_check_o);
`default_nettype wire

/* lsc_dp_model.sv */
// Datapath stand-in: destined data and result hold register.
`default_nettype none
module lsc_dp_model (
  // Clock and result chosen by the bench
  input  wire logic        mclk_i,
  input  wire logic [31:0] result_i,
  // Registers seen by the store
  output logic [31:0]      write_source_reg_o,
  output logic [31:0]      sum_hold_reg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Destined data follows the current result
  assign write_source_reg_o = result_i;
  // Hold register keeps last cycle's destined word for look-ahead
  always_ff @(posedge mclk_i) begin
    sum_hold_reg_o <= result_i;
  end
endmodule
`default_nettype wire

/* lsc_store_tb.sv */
// Self-checking bench for the checked dual local store.
`default_nettype none
module lsc_store_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lsc_pkg::*;
  logic        mclk_i, reset_i, mck_clear_i, xck, yck;
  lsc_cw_s     cw, idle;                  // Control word and idle word
  lsc_force_s  frc;                       // Forced address bits, kept off
  logic [7:0]  bix, gpr, msk, prot, bsel, diag, mck;
  logic [63:0] dw;                        // Pre-assembler doubleword
  logic [31:0] res, wsrc, shold, rty, ra, rb, ebus;
  int          error_cnt, check_count;
  lsc_store i_lsc_store (.mclk_i, .reset_i, .cw_i(cw), .force_i(frc), .base_index_reg_i(bix),
    .gpr_pointer_reg_i(gpr), .mask_aux_reg_i(msk), .pre_asm_dw_i(dw), .prot_key_i(prot),
    .write_source_reg_i(wsrc), .sum_hold_reg_i(shold), .byte_select_reg_i(bsel),
    .diag_control_zero_i(diag), .retry_hold_assembler_i(rty), .mck_clear_i, .first_input_reg_o(ra),
    .second_input_reg_o(rb), .external_input_bus_o(ebus), .machine_check_reg_one_o(mck),
    .x_check_o(xck), .y_check_o(yck));
  lsc_dp_model i_lsc_dp_model (.mclk_i, .result_i(res), .write_source_reg_o(wsrc), .sum_hold_reg_o(shold));
  // Clock of 5 ns
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Compare and count
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One control word per cycle, applied at the falling edge
  task automatic step(lsc_cw_s c);
    @(negedge mclk_i);
    cw = c;
  endtask
  // Destine a word, address from src_a or src_b field
  task automatic wr(logic [5:0] fa, logic [5:0] fb, logic db, logic [31:0] d);
    lsc_cw_s c;
    c = idle;
    c.src_a.field = fa;
    c.src_b.field = fb;
    c.dest_en = 1'b1;
    c.dest_b = db;
    step(c);
    res = d;
  endtask
  // Read both stacks, then wait for the registered answer
  task automatic rd(lsc_amode_e m, logic [5:0] fa, logic [5:0] fb);
    lsc_cw_s c;
    c = idle;
    c.src_a = '{1'b1, m, fa};
    c.src_b = '{1'b1, LSA_DIRECT, fb};
    step(c);
    step(idle);
  endtask
  // Back-to-back writes, both stacks, both address ends
  task automatic t_store();
    wr(6'h00, 6'h2a, 1'b0, 32'h1234_5678);
    wr(6'h15, 6'h3f, 1'b1, 32'h9abc_def0);
    step(idle);
    rd(LSA_DIRECT, 6'h00, 6'h3f);
    chk("stack_one lo", ra, 32'h1234_5678);
    chk("stack_two hi", rb, 32'h9abc_def0);
    rd(LSA_DIRECT, 6'h3f, 6'h00);
    chk("stack_one hi", ra, 32'h9abc_def0);
    chk("stack_two lo", rb, 32'h1234_5678);
    chk("checks clean", mck, 32'h0);
  endtask
  // Read of the location written in the same cycle
  task automatic t_bypass();
    wr(6'h21, 6'h21, 1'b0, 32'h0f0f_0f0f);
    step(idle);
    wr(6'h21, 6'h21, 1'b0, 32'hc3c3_3c3c);
    rd(LSA_DIRECT, 6'h21, 6'h21);
    chk("lookahead one", ra, 32'hc3c3_3c3c);
    chk("lookahead two", rb, 32'hc3c3_3c3c);
  endtask
  // Register numbers from either pointer nibble
  task automatic t_gpr();
    wr(6'h17, 6'h00, 1'b0, 32'h5a5a_0017);
    step(idle);
    gpr = 8'h7a;
    rd(LSA_GPR_HI, 6'h00, 6'h17);
    chk("gpr upper", ra, 32'h5a5a_0017);
    rd(LSA_FPR, 6'h00, 6'h17);
    chk("fpr upper", ra, 32'h5a5a_0017);
    gpr = 8'ha7;
    rd(LSA_GPR_LO, 6'h00, 6'h17);
    chk("gpr lower", ra, 32'h5a5a_0017);
  endtask
  // Word choice and single-byte routing
  task automatic t_asm();
    lsc_cw_s c;
    dw = 64'h0011_2233_4455_6677;
    c = idle;
    c.asm_mode = ASM_BYTE;
    for (int w = 0; w < 2; w++) begin
      bsel = 8'h00;
      bsel[LSC_SEL_WORD] = w[0];
      step(idle);
      step(idle);
      chk("word lanes", ebus, w ? 32'h4455_6677 : 32'h0011_2233);
    end
    for (int b = 0; b < 4; b++) begin
      bsel = {6'h00, b[1:0]};
      step(c);
      step(c);
      chk("byte lane", {24'h0, ebus[7:0]}, {24'h0, dw[63-8*b -: 8]});
    end
    // Odd halfword, odd byte pair, then the protect key in byte 3
    bsel = 8'h00;
    bsel[LSC_SEL_HALF] = 1'b1;
    bsel[LSC_SEL_BYTE] = 1'b1;
    c.asm_mode = ASM_HALF;
    step(c);
    step(c);
    chk("half lane", ebus, 32'h0000_2233);
    c.asm_mode = ASM_PAIR;
    step(c);
    step(c);
    chk("byte pair", ebus, 32'h0011_0033);
    c.asm_mode = ASM_WORD;
    c.prot = 1'b1;
    prot = 8'h5e;
    step(c);
    step(c);
    chk("protect key", ebus, 32'h0011_225e);
  endtask
  // Blocked stack_one write, sticky bits, clear
  task automatic t_diag();
    diag = 8'h08;
    rty = 32'hffff_fffd;
    wr(6'h05, 6'h05, 1'b0, 32'h7777_1111);
    step(idle);
    // Blocking must still stand at the deferred write edge
    step(idle);
    diag = 8'h00;
    rty = 32'hffff_ffff;
    rd(LSA_DIRECT, 6'h05, 6'h05);
    chk("stack_one blocked", ra, 32'h0);
    chk("stack_two written", rb, 32'h7777_1111);
    step(idle);
    chk("both checks set", {24'h0, mck & 8'h60}, 32'h60);
    mck_clear_i = 1'b1;
    step(idle);
    mck_clear_i = 1'b0;
    step(idle);
    chk("checks cleared", mck, 32'h0);
  endtask
  // Forced extra X or Y line during a write
  task automatic t_xy(logic [31:0] r, logic wx);
    logic sx, sy;
    sx = 1'b0;
    sy = 1'b0;
    diag = 8'h04;
    rty = r;
    wr(6'h09, 6'h09, 1'b0, 32'h0);
    step(idle);
    repeat (4) begin
      @(posedge mclk_i);
      #1;
      sx |= xck;
      sy |= yck;
    end
    // Return to the falling edge before touching inputs
    @(negedge mclk_i);
    diag = 8'h00;
    chk("x line check", sx, wx);
    chk("y line check", sy, !wx);
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk_i);
    error_cnt++;
    end_sim();
  end
  // Main sequence
  initial begin
    idle = '0;
    cw = '0;
    frc = '0;
    {bix, gpr, msk, prot, bsel, diag} = {8'h01, 40'h0};
    {dw, res, rty, mck_clear_i} = {96'h0, 32'hffff_ffff, 1'b0};
    reset_i = 1'b1;
    repeat (20) @(negedge mclk_i);
    reset_i = 1'b0;
    t_store();
    t_bypass();
    t_gpr();
    t_asm();
    t_diag();
    t_xy(32'hfbff_ffff, 1'b1);
    t_xy(32'hfdff_ffff, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
